// File: mbrs_frame_handler.sv
// Slave frame handler: gap delimiting, screening, response and delay

// Byte FIFO with back-pressure on both sides
module mbrs_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clear_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage array
  logic [AW-1:0] wr_ptr; // Write index
  logic [AW-1:0] rd_ptr; // Read index
  logic [AW:0] count; // Occupancy
  wire push = wr_valid_in && wr_ready_out; // Accepted write
  wire pop = rd_valid_out && rd_ready_in; // Accepted read
  assign wr_ready_out = (count != (AW+1)'(DEPTH));
  assign rd_valid_out = (count != '0);
  assign rd_data_out = mem[rd_ptr];
  // Storage write
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= wr_data_in;
    end
  end
  // Pointers and count
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (clear_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end
endmodule

// Top: receives bytes, screens frames, emits reply bytes
module mbrs_frame_handler #(
  parameter int unsigned TICK_CYCLES = mbrs_pkg::TICK_CYCLES,
  parameter int unsigned FIFO_DEPTH = mbrs_pkg::FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] node_addr_in,
  input wire logic [1:0] baud_sel_in,
  input wire logic [7:0] response_delay_setting_in,
  input wire logic [15:0] comm_timeout_setting_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_valid_in,
  input wire logic rx_error_in,
  output logic rx_ready_out,
  output logic [7:0] req_byte_out,
  output logic req_valid_out,
  input wire logic req_ready_in,
  output logic req_end_out,
  output logic req_broadcast_out,
  input wire logic exec_done_in,
  input wire logic [7:0] exec_exc_in,
  input wire logic [7:0] resp_byte_in,
  input wire logic resp_valid_in,
  output logic resp_ready_out,
  input wire logic resp_last_in,
  output logic [7:0] tx_byte_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  output logic tx_busy_out,
  output logic gap_fault_out,
  output logic comm_timeout_out
);
  typedef enum logic [2:0] {ST_RX, ST_EXEC, ST_DELAY, ST_SEND_RESP, ST_SEND_EXC, ST_SEND_CRC, ST_DONE} mbrs_state_t;
  mbrs_state_t state; // Main sequencer
  // CRC byte update, reflected polynomial
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ mbrs_pkg::CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
  // Tick divider
  logic [$clog2(TICK_CYCLES+1)-1:0] div_cnt; // Cycle counter within tick
  logic tick; // One-cycle 1 ms enable
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (div_cnt == ($bits(div_cnt))'(TICK_CYCLES-1));
      div_cnt <= (div_cnt == ($bits(div_cnt))'(TICK_CYCLES-1)) ? '0 : div_cnt + 1'b1;
    end
  end
  // Gap thresholds from baud selection
  wire [3:0] delim_gap = (baud_sel_in == mbrs_pkg::BAUD_4800) ? mbrs_pkg::DELIM_4800 :
    (baud_sel_in == mbrs_pkg::BAUD_9600) ? mbrs_pkg::DELIM_9600 :
    (baud_sel_in == mbrs_pkg::BAUD_19200) ? mbrs_pkg::DELIM_19200 : mbrs_pkg::DELIM_HIGHER;
  wire [3:0] fault_gap = (baud_sel_in == mbrs_pkg::BAUD_4800) ? mbrs_pkg::FAULT_4800 :
    (baud_sel_in == mbrs_pkg::BAUD_9600) ? mbrs_pkg::FAULT_9600 :
    (baud_sel_in == mbrs_pkg::BAUD_19200) ? mbrs_pkg::FAULT_19200 : mbrs_pkg::FAULT_HIGHER;
  // Receive-side state
  logic [3:0] idle_ticks; // Idle ticks since last byte
  logic in_frame; // Bytes seen since last delimiter
  logic [7:0] byte_cnt; // Frame length, saturating
  logic [15:0] rx_crc; // Running CRC over all bytes
  logic [7:0] first_byte; // Address byte
  logic [7:0] func_code; // Function code byte
  logic frame_err; // Parity or framing fault seen
  logic gap_fault; // Intra-frame gap seen
  wire rx_take = rx_valid_in && rx_ready_out && (state == ST_RX); // Byte accepted
  wire delim = in_frame && tick && !rx_take && ((idle_ticks + 4'd1) >= delim_gap);
  // Gap faults only when a byte follows it; the closing idle passes through it too
  wire gap_hit = rx_take && in_frame && (idle_ticks >= fault_gap) && (fault_gap < delim_gap);
  wire addr_ok = (first_byte == node_addr_in) || (first_byte == mbrs_pkg::BROADCAST_ADDR);
  wire is_bcast = (first_byte == mbrs_pkg::BROADCAST_ADDR);
  wire legal = addr_ok && (byte_cnt >= 8'(mbrs_pkg::MIN_FRAME_LEN)) && !frame_err;
  wire crc_ok = (rx_crc == 16'h0000); // Residue zero when CRC matches
  wire len_ok = crc_ok && !gap_fault;
  // Forward data bytes, withholding the two CRC bytes
  logic [7:0] hold0; // Two-byte delay line
  logic [7:0] hold1;
  logic [1:0] hold_n; // Bytes held
  wire fwd = rx_take && (hold_n == 2'd2); // Oldest byte released
  wire fifo_wr_ready; // Request FIFO space
  assign rx_ready_out = fifo_wr_ready && (state == ST_RX);
  logic fifo_clear; // Flush on rejected frame
  mbrs_fifo #(.WIDTH(mbrs_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_req_fifo (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .clear_in(fifo_clear),
    .wr_data_in(hold1),
    .wr_valid_in(fwd),
    .wr_ready_out(fifo_wr_ready),
    .rd_data_out(req_byte_out),
    .rd_valid_out(req_valid_out),
    .rd_ready_in(req_ready_in && (state == ST_EXEC))
  );
  // Byte capture and gap timing
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      idle_ticks <= '0;
      in_frame <= 1'b0;
      byte_cnt <= '0;
      rx_crc <= mbrs_pkg::CRC_INIT;
      first_byte <= '0;
      func_code <= '0;
      frame_err <= 1'b0;
      gap_fault <= 1'b0;
      hold0 <= '0;
      hold1 <= '0;
      hold_n <= '0;
    end else if (rx_take) begin
      idle_ticks <= '0;
      in_frame <= 1'b1;
      byte_cnt <= (byte_cnt == 8'hFF) ? byte_cnt : byte_cnt + 8'd1;
      rx_crc <= crc_step(rx_crc, rx_byte_in);
      if (byte_cnt == 8'd0) first_byte <= rx_byte_in;
      if (byte_cnt == 8'd1) func_code <= rx_byte_in;
      frame_err <= frame_err | rx_error_in;
      if (gap_hit) gap_fault <= 1'b1;
      hold0 <= rx_byte_in;
      hold1 <= hold0;
      hold_n <= (hold_n == 2'd2) ? hold_n : hold_n + 2'd1;
    end else if (state == ST_RX && delim) begin
      in_frame <= 1'b0; // Frame closed, fields kept for screening
    end else if (state == ST_RX && tick && in_frame) begin
      idle_ticks <= idle_ticks + 4'd1;
    end else if (state == ST_DONE) begin
      byte_cnt <= '0;
      rx_crc <= mbrs_pkg::CRC_INIT;
      frame_err <= 1'b0;
      gap_fault <= 1'b0;
      hold_n <= '0;
      idle_ticks <= '0;
    end
  end
  // Delay floor: delimit gap plus turnaround, in ticks
  wire [8:0] delay_floor = {5'h00, delim_gap} + 9'(mbrs_pkg::TURNAROUND_MS);
  wire [8:0] delay_req = {1'b0, response_delay_setting_in};
  wire [8:0] delay_eff = (delay_req > delay_floor) ? delay_req : delay_floor;
  // Sequencer registers
  logic [8:0] delay_ticks; // Ticks waited since frame end
  logic [7:0] exc_code; // Exception code held
  logic bcast; // Current frame is broadcast
  logic exc_sent; // Exception function code emitted
  logic [1:0] crc_idx; // CRC bytes sent; in ST_SEND_EXC, 1 once the address byte is sent
  logic [15:0] tx_crc; // Reply CRC
  logic [15:0] to_ticks; // Ticks since last valid frame
  logic first_valid; // A valid frame has been seen
  wire tx_go = !tx_valid_out || tx_ready_in; // Output slot free
  assign fifo_clear = (state == ST_RX) && delim && !(legal && len_ok);
  wire resp_take = (state == ST_SEND_RESP) && resp_valid_in && tx_go;
  assign resp_ready_out = (state == ST_SEND_RESP) && tx_go;
  wire valid_frame = (state == ST_RX) && delim && legal && len_ok;
  // Main sequencer
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= ST_RX;
      delay_ticks <= '0;
      exc_code <= '0;
      bcast <= 1'b0;
      exc_sent <= 1'b0;
      crc_idx <= '0;
      tx_crc <= mbrs_pkg::CRC_INIT;
      tx_byte_out <= '0;
      tx_valid_out <= 1'b0;
      req_end_out <= 1'b0;
      req_broadcast_out <= 1'b0;
      tx_busy_out <= 1'b0;
    end else begin
      req_end_out <= 1'b0;
      if (tx_valid_out && tx_ready_in) tx_valid_out <= 1'b0;
      unique case (state)
        ST_RX: begin
          if (delim) begin
            delay_ticks <= '0;
            bcast <= is_bcast;
            if (!legal) begin
              state <= ST_DONE;
            end else if (!len_ok) begin
              exc_code <= mbrs_pkg::EXC_ILL_FRAME;
              state <= is_bcast ? ST_DONE : ST_DELAY;
            end else begin
              req_end_out <= 1'b1;
              req_broadcast_out <= is_bcast;
              exc_code <= '0;
              state <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          if (tick) delay_ticks <= delay_ticks + 9'd1;
          if (exec_done_in) begin
            exc_code <= exec_exc_in;
            state <= bcast ? ST_DONE : ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (tick) delay_ticks <= delay_ticks + 9'd1;
          if (delay_ticks >= delay_eff) begin
            tx_crc <= mbrs_pkg::CRC_INIT;
            exc_sent <= 1'b0;
            crc_idx <= '0;
            tx_busy_out <= 1'b1;
            state <= (exc_code != 8'h00) ? ST_SEND_EXC : ST_SEND_RESP;
          end
        end
        ST_SEND_RESP: begin
          if (resp_take) begin
            tx_byte_out <= resp_byte_in;
            tx_valid_out <= 1'b1;
            tx_crc <= crc_step(tx_crc, resp_byte_in);
            if (resp_last_in) state <= ST_SEND_CRC;
          end
        end
        ST_SEND_EXC: begin
          if (tx_go) begin
            tx_valid_out <= 1'b1;
            if (crc_idx == 2'd0) begin
              tx_byte_out <= node_addr_in;
              tx_crc <= crc_step(tx_crc, node_addr_in);
              crc_idx <= 2'd1;
            end else if (!exc_sent) begin
              tx_byte_out <= func_code | mbrs_pkg::EXC_FLAG;
              tx_crc <= crc_step(tx_crc, func_code | mbrs_pkg::EXC_FLAG);
              exc_sent <= 1'b1;
            end else begin
              tx_byte_out <= exc_code;
              tx_crc <= crc_step(tx_crc, exc_code);
              crc_idx <= 2'd0;
              state <= ST_SEND_CRC;
            end
          end
        end
        ST_SEND_CRC: begin
          if (tx_go) begin
            tx_valid_out <= 1'b1;
            tx_byte_out <= (crc_idx == 2'd0) ? tx_crc[7:0] : tx_crc[15:8];
            crc_idx <= crc_idx + 2'd1;
            if (crc_idx == 2'd1) state <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (!tx_valid_out || tx_ready_in) begin
            tx_busy_out <= 1'b0;
            state <= ST_RX;
          end
        end
      endcase
    end
  end
  // Communication timeout between valid frames
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      to_ticks <= '0;
      first_valid <= 1'b0;
      comm_timeout_out <= 1'b0;
      gap_fault_out <= 1'b0;
    end else begin
      gap_fault_out <= gap_hit ? 1'b1 : (delim ? 1'b0 : gap_fault_out);
      if (valid_frame) begin
        to_ticks <= '0;
        first_valid <= 1'b1;
        comm_timeout_out <= 1'b0;
      end else if (tick && first_valid && comm_timeout_setting_in != 16'h0000) begin
        if (to_ticks != 16'hFFFF) to_ticks <= to_ticks + 16'd1;
        if (to_ticks >= comm_timeout_setting_in) comm_timeout_out <= 1'b1;
      end
    end
  end
  // Assertions
  a_exc_fc_msb: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (state == ST_SEND_EXC && tx_go && crc_idx == 2'd1 && !exc_sent) |=> tx_byte_out[7])
    else $error("exception function code lacks top bit");
  a_bcast_silent: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (bcast && state != ST_RX) |-> !(state inside {ST_SEND_RESP, ST_SEND_EXC}))
    else $error("broadcast frame answered");
  a_illegal_silent: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (state == ST_RX && delim && !legal) |=> state == ST_DONE)
    else $error("illegal frame not dropped");
  a_crc_exc: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (state == ST_RX && delim && legal && !len_ok) |=> exc_code == mbrs_pkg::EXC_ILL_FRAME)
    else $error("bad CRC not given code 03");
  a_delay_floor: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (state == ST_DELAY && $past(state) == ST_DELAY) ##1 (state != ST_DELAY) |-> $past(delay_ticks) >= delay_floor)
    else $error("reply delay below floor");
  a_delim_gap: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (delim) |-> ((idle_ticks + 4'd1) >= delim_gap) && !rx_take)
    else $error("frame closed early");
  a_timeout_off: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (comm_timeout_setting_in == 16'h0000 && !comm_timeout_out) |=> !comm_timeout_out)
    else $error("timeout raised while disabled");
  a_crc_order: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (state == ST_SEND_CRC && tx_go && crc_idx == 2'd0) |=> tx_byte_out == tx_crc[7:0])
    else $error("CRC low byte not first");
  a_short_illegal: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (state == ST_RX && delim && byte_cnt < 8'd3) |=> state == ST_DONE)
    else $error("short frame not dropped");
endmodule

// File: mbrs_frame_handler_test.sv
// Testbench for the slave frame handler against a master station model
module mbrs_frame_handler_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int T = 10; // Cycles per tick in simulation
  localparam logic [7:0] NODE = 8'h11; // Own station address
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [1:0] baud = mbrs_pkg::BAUD_9600; // Baud selector
  logic [7:0] dly = 8'h00; // Reply delay setting
  logic [15:0] tmo = 16'h0000; // Timeout setting, off at first
  logic [7:0] rx_byte, req_byte, tx_byte, exec_exc = 8'h00, resp_byte = 8'h00;
  logic rx_valid, rx_error, rx_ready, req_valid, req_end, req_bc, tx_valid, tx_ready, tx_busy, gap_f, tmo_f, resp_ready;
  logic req_ready = 1'b0, exec_done = 1'b0, resp_valid = 1'b0, resp_last = 1'b0, gap_seen = 1'b0;
  logic busy_at_tx = 1'b0; // Busy flag seen with the first reply byte
  logic [7:0] nil[$]; // Empty byte list
  int errors = 0, n_checks = 0, cyc = 0, first_tx = -1;
  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) cyc <= cyc + 1;
  // First reply byte and fault flag watchers
  always @(negedge clk_in) begin
    if (tx_valid === 1'b1 && first_tx < 0) begin
      first_tx = cyc;
      busy_at_tx = tx_busy;
    end
    if (gap_f === 1'b1) gap_seen = 1'b1;
  end
  mbrs_frame_handler #(.TICK_CYCLES(T), .FIFO_DEPTH(mbrs_pkg::FIFO_DEPTH)) mbrs_frame_handler_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .node_addr_in(NODE), .baud_sel_in(baud),
    .response_delay_setting_in(dly), .comm_timeout_setting_in(tmo), .rx_byte_in(rx_byte),
    .rx_valid_in(rx_valid), .rx_error_in(rx_error), .rx_ready_out(rx_ready), .req_byte_out(req_byte),
    .req_valid_out(req_valid), .req_ready_in(req_ready), .req_end_out(req_end), .req_broadcast_out(req_bc),
    .exec_done_in(exec_done), .exec_exc_in(exec_exc), .resp_byte_in(resp_byte), .resp_valid_in(resp_valid),
    .resp_ready_out(resp_ready), .resp_last_in(resp_last), .tx_byte_out(tx_byte), .tx_valid_out(tx_valid),
    .tx_ready_in(tx_ready), .tx_busy_out(tx_busy), .gap_fault_out(gap_f), .comm_timeout_out(tmo_f));
  mbrs_master_model mbrs_master_model_i (
    .clk_in(clk_in), .rx_ready_in(rx_ready), .rx_byte_out(rx_byte), .rx_valid_out(rx_valid),
    .rx_error_out(rx_error), .tx_byte_in(tx_byte), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready));
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step();
    @(posedge clk_in);
    #2;
  endtask
  // Delimit gap in ticks for a baud code
  function automatic int delim(input logic [1:0] b);
    case (b)
      mbrs_pkg::BAUD_4800: return int'(mbrs_pkg::DELIM_4800);
      mbrs_pkg::BAUD_9600: return int'(mbrs_pkg::DELIM_9600);
      mbrs_pkg::BAUD_19200: return int'(mbrs_pkg::DELIM_19200);
      default: return int'(mbrs_pkg::DELIM_HIGHER);
    endcase
  endfunction
  // Appends the checksum, low byte first
  function automatic void add_crc(ref logic [7:0] f[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (f[i]) begin
      c = c ^ {8'h00, f[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
  endfunction
  // Sends a frame and watches for the execute strobe
  task automatic frame(input logic [7:0] f[$], input int gap, input int err_at, input logic exp_end, output int last);
    int took, n;
    logic seen;
    seen = 1'b0;
    step();
    mbrs_master_model_i.got_q.delete();
    first_tx = -1;
    mbrs_master_model_i.send_frame(f, gap, err_at, took);
    last = cyc;
    for (n = 0; n < (delim(baud) + 3) * T && !seen; n++) begin
      @(negedge clk_in);
      seen = (req_end === 1'b1);
    end
    check("req_end", seen, exp_end);
    if (seen) check("end_gap", (cyc - last) >= (delim(baud) - 1) * T && (cyc - last) <= (delim(baud) + 1) * T + 3, 1'b1);
  endtask
  // Drains request bytes with stalls, reports result, feeds reply
  task automatic execute(input logic [7:0] req[$], input logic [7:0] exc, input logic [7:0] resp[$]);
    int n, i;
    logic acc;
    i = 0;
    for (n = 0; n < 200 && i < req.size(); n++) begin
      step();
      req_ready = n[0];
      @(negedge clk_in);
      if (req_valid === 1'b1 && req_ready) begin
        check("req_byte", req_byte, req[i]);
        i++;
      end
    end
    check("req_count", 16'(i), 16'(req.size()));
    step();
    req_ready = 1'b0;
    exec_exc = exc;
    exec_done = 1'b1;
    step();
    exec_done = 1'b0;
    foreach (resp[k]) begin
      resp_byte = resp[k];
      resp_last = (k == resp.size() - 1);
      resp_valid = 1'b1;
      acc = 1'b0;
      for (n = 0; n < 400 && !acc; n++) begin
        @(negedge clk_in);
        acc = (resp_ready === 1'b1);
        step();
      end
      if (!acc) check("resp_ready", 1'b0, 1'b1);
    end
    resp_valid = 1'b0;
    resp_last = 1'b0;
  endtask
  // Waits for the reply and compares it byte by byte
  task automatic reply(input logic [7:0] exp[$], input int min_dly, input int last);
    int n, want;
    logic [7:0] got[$];
    want = exp.size() > 0 ? exp.size() : 1;
    for (n = 0; n < 1500 && mbrs_master_model_i.got_q.size() < want; n++) @(negedge clk_in);
    got = mbrs_master_model_i.got_q;
    check("reply_len", 16'(got.size()), 16'(exp.size()));
    foreach (exp[i]) if (i < got.size()) check("reply_byte", got[i], exp[i]);
    if (min_dly > 0) check("reply_delay", first_tx - last >= (min_dly - 1) * T, 1'b1);
    if (exp.size() > 0) check("tx_busy", busy_at_tx, 1'b1);
    step();
    check("tx_idle", tx_busy, 1'b0);
  endtask
  task automatic t_normal(input logic [1:0] b, input logic [7:0] set);
    logic [7:0] f[$], rq[$], rs[$];
    int last;
    baud = b;
    dly = set;
    f = '{NODE, 8'h03, 8'h00, 8'h05};
    rq = f;
    add_crc(f);
    rs = '{NODE, 8'h03, 8'h02, 8'hAB, 8'hCD};
    frame(f, 0, -1, 1'b1, last);
    check("broadcast", req_bc, 1'b0);
    execute(rq, 8'h00, rs);
    add_crc(rs);
    reply(rs, (int'(set) > delim(b) + 1) ? int'(set) : delim(b) + 1, last);
  endtask
  task automatic t_exc();
    logic [7:0] c[$], f[$], rq[$], e[$];
    int last;
    c = '{mbrs_pkg::EXC_ILL_FUNC, mbrs_pkg::EXC_ILL_ADDR, mbrs_pkg::EXC_SLAVE_FAIL, mbrs_pkg::EXC_RANGE,
          mbrs_pkg::EXC_READ_ONLY, mbrs_pkg::EXC_RUN_LOCK, mbrs_pkg::EXC_PASSWORD};
    baud = mbrs_pkg::BAUD_9600;
    dly = 8'h00;
    foreach (c[i]) begin
      f = '{NODE, 8'h06, 8'h70, 8'h00};
      rq = f;
      add_crc(f);
      frame(f, 0, -1, 1'b1, last);
      execute(rq, c[i], nil);
      e = '{NODE, 8'h06 | mbrs_pkg::EXC_FLAG, c[i]};
      add_crc(e);
      reply(e, 0, last);
    end
  endtask
  // Broken checksum or in-frame gap: code 03, nothing executed
  task automatic t_bad_frame(input int gap);
    logic [7:0] f[$], e[$];
    int last;
    f = '{NODE, 8'h03, 8'h00, 8'h05};
    add_crc(f);
    if (gap == 0) f[f.size() - 1] = f[f.size() - 1] ^ 8'h5A;
    gap_seen = 1'b0;
    frame(f, gap, -1, 1'b0, last);
    check("gap_fault", gap_seen, gap > 0);
    e = '{NODE, 8'h03 | mbrs_pkg::EXC_FLAG, mbrs_pkg::EXC_ILL_FRAME};
    add_crc(e);
    reply(e, 0, last);
  endtask
  // Wrong address, short frame, byte error: all silent
  task automatic t_silent();
    logic [7:0] f[$];
    int last;
    for (int k = 0; k < 3; k++) begin
      f = '{(k == 0) ? NODE + 8'h01 : NODE, 8'h03, 8'h00, 8'h05};
      add_crc(f);
      if (k == 1) f = '{NODE, 8'h03};
      frame(f, 0, (k == 2) ? 2 : -1, 1'b0, last);
      reply(nil, 0, last);
    end
  endtask
  task automatic t_broadcast();
    logic [7:0] f[$], rq[$];
    int last;
    f = '{mbrs_pkg::BROADCAST_ADDR, 8'h06, 8'h70, 8'h01};
    rq = f;
    add_crc(f);
    frame(f, 0, -1, 1'b1, last);
    check("broadcast", req_bc, 1'b1);
    execute(rq, 8'h00, nil);
    reply(nil, 0, last);
  endtask
  // Timeout off, then armed after a valid frame
  task automatic t_timeout();
    logic seen;
    check("timeout_off", tmo_f, 1'b0);
    tmo = 16'h001E;
    t_normal(mbrs_pkg::BAUD_9600, 8'h00);
    seen = 1'b0;
    for (int n = 0; n < 45 * T && !seen; n++) begin
      @(negedge clk_in);
      seen = (tmo_f === 1'b1);
    end
    check("timeout_on", seen, 1'b1);
  endtask
  // Fills the buffer until refused, then resets mid-run
  task automatic t_full();
    logic [7:0] f[$];
    int took;
    for (int k = 0; k < 40; k++) f.push_back((k == 0) ? NODE : 8'(k));
    step();
    mbrs_master_model_i.send_frame(f, 0, -1, took);
    check("fill_refused", took >= 32 && took <= 34, 1'b1);
    step();
    sys_rst_in = 1'b1;
    repeat (8) step();
    check("reset_outputs", {tx_busy, tx_valid, req_end, gap_f, tmo_f}, 5'h00);
    sys_rst_in = 1'b0;
    tmo = 16'h0000;
    t_normal(mbrs_pkg::BAUD_HIGHER, 8'h00);
  endtask
  initial begin
    repeat (8) step();
    sys_rst_in = 1'b0;
    for (int b = 0; b < 4; b++) t_normal(2'(b), 8'h00);
    t_normal(mbrs_pkg::BAUD_9600, 8'h14);
    t_exc();
    t_bad_frame(0);
    t_bad_frame(25);
    t_silent();
    t_broadcast();
    t_timeout();
    t_full();
    report_and_stop();
  end
endmodule

// File: mbrs_master_model.sv
// Master station model: sends request frames and collects reply bytes
module mbrs_master_model (
  input wire logic clk_in,
  input wire logic rx_ready_in,
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out,
  output logic rx_error_out,
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got_q[$]; // Reply bytes as accepted
  int stall = 0; // Reply stall pattern counter
  initial begin
    rx_byte_out = 8'h00;
    rx_valid_out = 1'b0;
    rx_error_out = 1'b0;
    tx_ready_out = 1'b0;
  end
  // Reply side refuses one cycle in three
  always @(posedge clk_in) begin
    stall <= stall + 1;
    tx_ready_out <= #2 (stall % 3 != 2);
  end
  // Handshake state seen here equals that at the next edge
  always @(negedge clk_in) begin
    if (tx_valid_in === 1'b1 && tx_ready_out) got_q.push_back(tx_byte_in);
  end
  // Sends bytes back to back, optional gap after the second one
  task automatic send_frame(input logic [7:0] f[$], input int gap, input int err_at, output int took);
    logic acc;
    took = 0;
    acc = 1'b1;
    foreach (f[i]) begin
      if (acc) begin
        rx_byte_out = f[i];
        rx_error_out = (i == err_at);
        rx_valid_out = 1'b1;
        acc = 1'b0;
        for (int n = 0; n < 60 && !acc; n++) begin
          @(negedge clk_in);
          acc = (rx_ready_in === 1'b1);
          @(posedge clk_in);
          #2;
        end
        took += acc;
        // Deliberate idle inside the frame
        if (acc && i == 1 && gap > 0) begin
          rx_valid_out = 1'b0;
          rx_byte_out = ~f[i];
          repeat (gap) @(posedge clk_in);
          #2;
        end
      end
    end
    // Released line shows no stale byte; idle closes the frame
    rx_valid_out = 1'b0;
    rx_error_out = 1'b0;
    rx_byte_out = ~rx_byte_out;
  endtask
endmodule

// File: mbrs_pkg.sv
// Package of constants for the slave frame handler
package mbrs_pkg;
  // Clock and tick timing
  localparam int unsigned CLK_HZ = 40_000_000; // System clock rate
  localparam int unsigned TICK_MS = 1; // Sampling tick period in ms
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS; // Cycles per tick
  localparam int unsigned TURNAROUND_MS = 1; // Transceiver turnaround wait
  // Baud selector codes
  localparam logic [1:0] BAUD_4800 = 2'h0;
  localparam logic [1:0] BAUD_9600 = 2'h1;
  localparam logic [1:0] BAUD_19200 = 2'h2;
  localparam logic [1:0] BAUD_HIGHER = 2'h3;
  // Gap tables in ticks
  localparam logic [3:0] DELIM_4800 = 4'h8;
  localparam logic [3:0] FAULT_4800 = 4'h4;
  localparam logic [3:0] DELIM_9600 = 4'h4;
  localparam logic [3:0] FAULT_9600 = 4'h2;
  localparam logic [3:0] DELIM_19200 = 4'h2;
  localparam logic [3:0] FAULT_19200 = 4'h1;
  localparam logic [3:0] DELIM_HIGHER = 4'h1;
  localparam logic [3:0] FAULT_HIGHER = 4'h1;
  // Frame fields
  localparam logic [7:0] BROADCAST_ADDR = 8'h00;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam int unsigned MIN_FRAME_LEN = 3;
  // CRC
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  // Exception codes
  localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILL_FRAME = 8'h03;
  localparam logic [7:0] EXC_SLAVE_FAIL = 8'h04;
  localparam logic [7:0] EXC_RANGE = 8'h05;
  localparam logic [7:0] EXC_READ_ONLY = 8'h06;
  localparam logic [7:0] EXC_RUN_LOCK = 8'h07;
  localparam logic [7:0] EXC_PASSWORD = 8'h08;
  // Buffer geometry
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned DATA_W = 8;
endpackage
